// [ssr_status.sv]
`timescale 1ns/10ps
`include "ssr_cfg.svh"

// Notes on behaviour
// - a serial poll returns the current poll status byte.
// - poll status byte is zero right after power-up.
// - byte layout: 6 request/summary, 5 event, 4 message, 3 error; others zero.
// - request bit sets when an enabled summary bit rises from 0 to 1.
// - service request line is active while the request bit is 1.
// - master summary is 1 while any enabled summary is 1; readable by query.
// - message-available follows pending response data in the output buffer.
// - error-available follows a non-empty error queue.
// - serial poll, clear-status or master summary low clear request and line.
// - master summary clears only when enabled summaries are all zero.
// - mask bit 1 passes its status bit, 0 blocks it; mask resets to zero.
// - event latch holds 8 bits, read as 16; upper byte always reads zero.
// - event latch clears at power-on and on every read of it.
// - event bits: 7 power-on, 5 command, 4 execution, 3 device, 2 query, 0 done.
// - command error sets bit 5 when its event mask bit allows it.
// - any enabled set event bit raises the event summary bit.
// - event bits hold until read, device clear, reset or clear-status.
// - event mask resets to zero at power-on.
// - power-on event bit is set after power has been cycled.
// - execution failure sets the execution error bit.
// - device-specific failure sets the device-dependent error bit.
// - talk with nothing to say or data not collected sets query error.
// - done bit sets once prior commands finish after the completion command.
// - clear-status zeroes events, empties error queue, drops request and completion wait.
// - reading the event mask leaves it; reads give bits 0 through 7, upper byte zero; here bits 1 and 6 are never stored and read zero.

module ssr_status #(
   parameter logic EXTRA_SUMMARY_EN = 1'b0
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire ssr_pkg::ssr_cmd_s cmd_i,
   input  wire ssr_pkg::ssr_evt_s evt_i,
   input  wire ssr_pkg::ssr_sum_s sum_i,
   input  wire logic              dev_clear_i,
   input  wire logic              spoll_i,
   input  wire logic              ops_idle_i,
   output logic                   resp_valid_o,
   output logic [15:0]            resp_data_o,
   output logic                   spoll_valid_o,
   output logic [7:0]             spoll_byte_o,
   output logic                   srq_o,
   output logic [7:0]             stb_o,
   output logic                   err_clear_o
);

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [15:0] widen(input logic [7:0] b);
      widen = {8'h00, b};
   endfunction : widen

   function automatic logic [3:0] enabled_sums(input logic [7:0] stb,
                                               input logic [7:0] service_request_mask,
                                               input logic       extra);
      enabled_sums = {stb[`SSR_STB_ESB_BIT] & service_request_mask[`SSR_STB_ESB_BIT],
                      stb[`SSR_STB_MAV_BIT] & service_request_mask[`SSR_STB_MAV_BIT],
                      stb[`SSR_STB_EAV_BIT] & service_request_mask[`SSR_STB_EAV_BIT],
                      extra & EXTRA_SUMMARY_EN};
   endfunction : enabled_sums

   ssr_pkg::ssr_state_s state_reg;
   ssr_pkg::ssr_state_s state_next;

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic [7:0] esr_set;
      logic [7:0] esr_base;
      logic [7:0] stb_raw;
      logic [3:0] sums;
      logic       master_summary_bit;
      logic       rqs_rise;
      logic       rqs_clr;
      logic       cmd_cls;
      logic       cmd_rst;
      logic       cmd_opc;
      esr_set    = 8'h00;
      esr_base   = state_reg.event_status_latch;
      stb_raw    = 8'h00;
      sums       = 4'h0;
      master_summary_bit        = 1'b0;
      rqs_rise   = 1'b0;
      rqs_clr    = 1'b0;
      cmd_cls    = cmd_i.valid && (cmd_i.cmd == ssr_pkg::SSR_CMD_CLS);
      cmd_rst    = cmd_i.valid && (cmd_i.cmd == ssr_pkg::SSR_CMD_RST);
      cmd_opc    = cmd_i.valid && (cmd_i.cmd == ssr_pkg::SSR_CMD_OPC);
      state_next = state_reg;

      state_next.resp_valid  = 1'b0;
      state_next.spoll_valid = 1'b0;
      state_next.err_clear   = 1'b0;

      // ----------------------------------------------------------------------
      // event sources, latched on the reporting cycle
      // ----------------------------------------------------------------------
      esr_set[`SSR_ESR_PON_BIT] = state_reg.pon_pending;
      esr_set[`SSR_ESR_CME_BIT] = evt_i.command_error_event & state_reg.event_status_mask[`SSR_ESR_CME_BIT];
      esr_set[`SSR_ESR_EXE_BIT] = evt_i.execution_error_event;
      esr_set[`SSR_ESR_DDE_BIT] = evt_i.dde;
      esr_set[`SSR_ESR_QYE_BIT] = evt_i.query_error_event;
      state_next.pon_pending = 1'b0;

      // completion tracking; clear-status cancels a waiting request
      case (state_reg.operation_complete_event)
         ssr_pkg::SSR_OPC_IDLE: begin
            if (cmd_opc) begin
               state_next.operation_complete_event = ssr_pkg::SSR_OPC_WAIT;
            end
         end
         ssr_pkg::SSR_OPC_WAIT: begin
            if (cmd_cls || cmd_rst || dev_clear_i) begin
               state_next.operation_complete_event = ssr_pkg::SSR_OPC_IDLE;
            end else if (ops_idle_i) begin
               esr_set[`SSR_ESR_OPC_BIT] = 1'b1;
               state_next.operation_complete_event = ssr_pkg::SSR_OPC_IDLE;
            end
         end
         default: begin
            state_next.operation_complete_event = ssr_pkg::SSR_OPC_IDLE;
         end
      endcase

      // ----------------------------------------------------------------------
      // commands from the parser
      // ----------------------------------------------------------------------
      if (cmd_i.valid) begin
         case (cmd_i.cmd)
            ssr_pkg::SSR_CMD_READ_STB: begin
               state_next.resp_valid = 1'b1;
               state_next.resp_data  = widen(state_reg.stb);
            end
            ssr_pkg::SSR_CMD_READ_SRE: begin
               state_next.resp_valid = 1'b1;
               state_next.resp_data  = widen(state_reg.service_request_mask);
            end
            ssr_pkg::SSR_CMD_WRITE_SRE: begin
               state_next.service_request_mask = cmd_i.data[7:0] & `SSR_STB_USED;
            end
            ssr_pkg::SSR_CMD_READ_ESR: begin
               state_next.resp_valid = 1'b1;
               state_next.resp_data  = widen(state_reg.event_status_latch);
               esr_base              = 8'h00;
            end
            ssr_pkg::SSR_CMD_READ_ESE: begin
               state_next.resp_valid = 1'b1;
               state_next.resp_data  = widen(state_reg.event_status_mask);
            end
            ssr_pkg::SSR_CMD_WRITE_ESE: begin
               state_next.event_status_mask = cmd_i.data[7:0] & `SSR_ESR_USED;
            end
            ssr_pkg::SSR_CMD_CLS: begin
               esr_base             = 8'h00;
               state_next.err_clear = 1'b1;
            end
            ssr_pkg::SSR_CMD_RST: begin
               esr_base = 8'h00;
            end
            default: begin
            end
         endcase
      end
      if (dev_clear_i) begin
         esr_base = 8'h00;
      end

      // a new event in the clearing cycle still lands
      state_next.event_status_latch = (esr_base | esr_set) & `SSR_ESR_USED;

      // ----------------------------------------------------------------------
      // status byte and service request
      // ----------------------------------------------------------------------
      stb_raw[`SSR_STB_ESB_BIT] = |(state_reg.event_status_latch & state_reg.event_status_mask);
      stb_raw[`SSR_STB_MAV_BIT] = sum_i.message_available_bit;
      stb_raw[`SSR_STB_EAV_BIT] = sum_i.error_available_bit;
      sums = enabled_sums(stb_raw, state_reg.service_request_mask, sum_i.extra);
      master_summary_bit  = |sums;
      // only fresh rising edges may request again
      rqs_rise = |(sums & ~state_reg.sum_prev);
      rqs_clr  = spoll_i || cmd_cls || !master_summary_bit;
      state_next.sum_prev = sums;
      if (rqs_rise) begin
         state_next.requesting_service_bit = 1'b1;
      end else if (rqs_clr) begin
         state_next.requesting_service_bit = 1'b0;
      end
      state_next.srq = state_next.requesting_service_bit;
      stb_raw[`SSR_STB_MSS_BIT] = master_summary_bit;
      state_next.stb = stb_raw & `SSR_STB_USED;

      // serial poll answers with the request bit in place of the summary
      if (spoll_i) begin
         state_next.spoll_valid = 1'b1;
         state_next.spoll_byte  = (stb_raw & ~(8'h01 << `SSR_STB_RQS_BIT))
                                  | ({7'h00, state_reg.requesting_service_bit} << `SSR_STB_RQS_BIT);
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg.service_request_mask         <= `SSR_SRE_RESET;
         state_reg.event_status_mask         <= 8'(`SSR_ESE_RESET);
         state_reg.event_status_latch         <= 8'(`SSR_ESR_RESET);
         state_reg.requesting_service_bit         <= 1'b0;
         state_reg.sum_prev    <= 4'h0;
         state_reg.operation_complete_event         <= ssr_pkg::SSR_OPC_IDLE;
         state_reg.pon_pending <= 1'b1;
         state_reg.resp_valid  <= 1'b0;
         state_reg.resp_data   <= 16'h0000;
         state_reg.spoll_valid <= 1'b0;
         state_reg.spoll_byte  <= `SSR_STB_RESET;
         state_reg.err_clear   <= 1'b0;
         state_reg.srq         <= 1'b0;
         state_reg.stb         <= `SSR_STB_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------------
   // outputs, all straight from the state register
   // ----------------------------------------------------------------------
   assign resp_valid_o  = state_reg.resp_valid;
   assign resp_data_o   = state_reg.resp_data;
   assign spoll_valid_o = state_reg.spoll_valid;
   assign spoll_byte_o  = state_reg.spoll_byte;
   assign srq_o         = state_reg.srq;
   assign stb_o         = state_reg.stb;
   assign err_clear_o   = state_reg.err_clear;

endmodule : ssr_status

// [ssr_cfg.svh]
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

// ----------------------------------------------------------------------
// poll status byte and service request mask layout
// ----------------------------------------------------------------------
`define SSR_STB_W        8
`define SSR_STB_RQS_BIT  6
`define SSR_STB_MSS_BIT  6
`define SSR_STB_ESB_BIT  5
`define SSR_STB_MAV_BIT  4
`define SSR_STB_EAV_BIT  3
`define SSR_STB_USED     8'h78
`define SSR_SRE_RESET    8'h00
`define SSR_STB_RESET    8'h00

// ----------------------------------------------------------------------
// event status latch and mask layout
// ----------------------------------------------------------------------
`define SSR_ESR_W        16
`define SSR_ESR_PON_BIT  7
`define SSR_ESR_CME_BIT  5
`define SSR_ESR_EXE_BIT  4
`define SSR_ESR_DDE_BIT  3
`define SSR_ESR_QYE_BIT  2
`define SSR_ESR_OPC_BIT  0
`define SSR_ESR_USED     8'hBD
`define SSR_ESR_RESET    16'h0000
`define SSR_ESE_RESET    16'h0000

`endif

// [ssr_pkg.sv]
package ssr_pkg;

   // ----------------------------------------------------------------------
   // commands handed over by the command parser
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      SSR_CMD_NONE      = 4'h0,
      SSR_CMD_READ_STB  = 4'h1,
      SSR_CMD_READ_SRE  = 4'h2,
      SSR_CMD_WRITE_SRE = 4'h3,
      SSR_CMD_READ_ESR  = 4'h4,
      SSR_CMD_READ_ESE  = 4'h5,
      SSR_CMD_WRITE_ESE = 4'h6,
      SSR_CMD_CLS       = 4'h7,
      SSR_CMD_RST       = 4'h8,
      SSR_CMD_OPC       = 4'h9
   } ssr_cmd_e;

   typedef enum logic [1:0] {
      SSR_OPC_IDLE = 2'b01,
      SSR_OPC_WAIT = 2'b10
   } ssr_opc_e;

   typedef struct packed {
      logic        valid;
      ssr_cmd_e    cmd;
      logic [15:0] data;
   } ssr_cmd_s;

   typedef struct packed {
      logic command_error_event;
      logic execution_error_event;
      logic dde;
      logic query_error_event;
   } ssr_evt_s;

   typedef struct packed {
      logic message_available_bit;
      logic error_available_bit;
      logic extra;
   } ssr_sum_s;

   typedef struct packed {
      logic [7:0]  service_request_mask;
      logic [7:0]  event_status_mask;
      logic [7:0]  event_status_latch;
      logic        requesting_service_bit;
      logic [3:0]  sum_prev;
      ssr_opc_e    operation_complete_event;
      logic        pon_pending;
      logic        resp_valid;
      logic [15:0] resp_data;
      logic        spoll_valid;
      logic [7:0]  spoll_byte;
      logic        err_clear;
      logic        srq;
      logic [7:0]  stb;
   } ssr_state_s;

endpackage : ssr_pkg

// [ssr_status_checker.sv]
`timescale 1ns/10ps

module ssr_status_checker (
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire ssr_pkg::ssr_cmd_s cmd_i,
   input wire ssr_pkg::ssr_sum_s sum_i,
   input wire logic              spoll_i,
   input wire logic              resp_valid_o,
   input wire logic [15:0]       resp_data_o,
   input wire logic              spoll_valid_o,
   input wire logic [7:0]        spoll_byte_o,
   input wire logic              srq_o,
   input wire logic [7:0]        stb_o,
   input wire logic              err_clear_o
);
   // ----------------
   // port relations
   // ----------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic rd_cmd;
   assign rd_cmd = cmd_i.valid && cmd_i.cmd inside {ssr_pkg::SSR_CMD_READ_STB,
      ssr_pkg::SSR_CMD_READ_SRE, ssr_pkg::SSR_CMD_READ_ESR, ssr_pkg::SSR_CMD_READ_ESE};

   stb_pad_zero_a: assert property (stb_o[7] == 1'b0 && stb_o[2:0] == 3'h0)
      else $error("status byte pad bits set");
   resp_upper_a: assert property (resp_valid_o |-> resp_data_o[15:8] == 8'h00)
      else $error("answer upper byte set");
   read_answer_a: assert property (rd_cmd |=> resp_valid_o)
      else $error("read gave no answer");
   no_answer_a: assert property (!rd_cmd |=> !resp_valid_o)
      else $error("answer without read");
   poll_answer_a: assert property (!$past(rst_i) |-> spoll_valid_o == $past(spoll_i))
      else $error("poll answer timing");
   poll_rqs_a: assert property (spoll_i && srq_o |=> spoll_byte_o[6])
      else $error("poll byte lost request bit");
   sum_track_a: assert property (!$past(rst_i) |-> stb_o[4] == $past(sum_i.message_available_bit)
      && stb_o[3] == $past(sum_i.error_available_bit)) else $error("summary bits lag");
   clear_pulse_a: assert property (cmd_i.valid && cmd_i.cmd == ssr_pkg::SSR_CMD_CLS
      |=> err_clear_o) else $error("no error queue clear");
   mss_gate_a: assert property ($fell(stb_o[6]) |-> ##[0:1] !srq_o)
      else $error("request kept after summary fell");
   power_reset_a: assert property (disable iff (1'b0) rst_i |=> stb_o == 8'h00 && !srq_o)
      else $error("status not zero after reset");
endmodule : ssr_status_checker

bind ssr_status ssr_status_checker ssr_status_checker_i (
   .clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd_i), .sum_i(sum_i), .spoll_i(spoll_i),
   .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o), .spoll_valid_o(spoll_valid_o),
   .spoll_byte_o(spoll_byte_o), .srq_o(srq_o), .stb_o(stb_o), .err_clear_o(err_clear_o)
);

// [ssr_ctl_model.sv]
`timescale 1ns/10ps

module ssr_ctl_model (
   input  wire logic       clk_i,
   input  wire logic       srq_i,
   input  wire logic       en_i,
   input  wire logic [3:0] wait_i,
   output logic            spoll_o
);
   // ----------------
   // polling controller
   // ----------------
   logic [3:0] cnt = 4'h0;
   initial spoll_o = 1'b0;
   // skip the cycle of its own poll, the line drops one edge later
   always @(posedge clk_i) begin
      cnt <= (en_i && srq_i && !spoll_o && cnt < wait_i) ? cnt + 4'h1 : 4'h0;
      spoll_o <= #2 (en_i && srq_i && !spoll_o && cnt == wait_i);
   end
endmodule : ssr_ctl_model

// [ssr_status_tb.sv]
`timescale 1ns/10ps

module ssr_status_tb;
   logic              clk_i = 1'b0, rst_i = 1'b1, dev_clear_i = 1'b0, ops_idle_i = 1'b1;
   ssr_pkg::ssr_cmd_s cmd_i = '0;
   ssr_pkg::ssr_evt_s evt_i = '0;
   ssr_pkg::ssr_sum_s sum_i = '0;
   logic              spoll_i, resp_valid_o, spoll_valid_o, srq_o, err_clear_o;
   logic [15:0]       resp_data_o;
   logic [7:0]        spoll_byte_o, stb_o;
   logic              poll_en = 1'b0;
   logic [3:0]        poll_wait = 4'h0;
   int                fail_count = 0, tests_run = 0;

   ssr_status ssr_status_i (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd_i), .evt_i(evt_i),
      .sum_i(sum_i), .dev_clear_i(dev_clear_i), .spoll_i(spoll_i), .ops_idle_i(ops_idle_i),
      .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o), .spoll_valid_o(spoll_valid_o),
      .spoll_byte_o(spoll_byte_o), .srq_o(srq_o), .stb_o(stb_o), .err_clear_o(err_clear_o));
   ssr_ctl_model ssr_ctl_model_i (.clk_i(clk_i), .srq_i(srq_o), .en_i(poll_en),
      .wait_i(poll_wait), .spoll_o(spoll_i));

   // ----------------
   // access tasks
   // ----------------
   always #12.5 clk_i = ~clk_i;

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask : tick

   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic cmd(input ssr_pkg::ssr_cmd_e code, input logic [15:0] data);
      tick(1);
      cmd_i = '{valid: 1'b1, cmd: code, data: data};
      tick(1);
      cmd_i.valid = 1'b0;
   endtask : cmd

   task automatic rd(input ssr_pkg::ssr_cmd_e code, input logic [15:0] exp);
      cmd(code, 16'h0000);
      chk({resp_valid_o, 15'h0000}, 16'h8000);
      chk(resp_data_o, exp);
   endtask : rd

   task automatic evt(input logic [3:0] e);
      tick(1);
      evt_i = ssr_pkg::ssr_evt_s'(e);
      tick(1);
      evt_i = '0;
   endtask : evt

   // bounded: a controller that never polls ends the run
   task automatic wait_poll(input logic [7:0] exp);
      int i;
      for (i = 0; i < 40 && spoll_valid_o !== 1'b1; i++) tick(1);
      chk({7'h00, srq_o, spoll_byte_o}, {8'h00, exp});
      if (i == 40) begin
         fail_count++;
         close_out();
      end
   endtask : wait_poll

   initial begin
      tick(6);
      rst_i = 1'b0;
      chk({8'h00, stb_o}, 16'h0000);
      rd(ssr_pkg::SSR_CMD_READ_ESR, 16'h0080);
      evt(4'h8);
      rd(ssr_pkg::SSR_CMD_READ_ESR, 16'h0000);
      cmd(ssr_pkg::SSR_CMD_WRITE_ESE, 16'hffff);
      rd(ssr_pkg::SSR_CMD_READ_ESE, 16'h00bd);
      cmd(ssr_pkg::SSR_CMD_WRITE_SRE, 16'hffff);
      rd(ssr_pkg::SSR_CMD_READ_SRE, 16'h0078);
      poll_en = 1'b1;
      evt(4'hf);
      wait_poll(8'h60);
      rd(ssr_pkg::SSR_CMD_READ_ESR, 16'h003c);
      poll_en = 1'b0;
      poll_wait = 4'h5;
      sum_i.message_available_bit = 1'b1;
      tick(1);
      chk({7'h00, srq_o, stb_o}, 16'h0150);
      poll_en = 1'b1;
      wait_poll(8'h50);
      poll_en = 1'b0;
      tick(4);
      chk({15'h0000, srq_o}, 16'h0000);
      cmd(ssr_pkg::SSR_CMD_WRITE_SRE, 16'h0008);
      sum_i.message_available_bit = 1'b0;
      tick(1);
      chk({8'h00, stb_o}, 16'h0000);
      sum_i.error_available_bit = 1'b1;
      tick(1);
      chk({7'h00, srq_o, stb_o}, 16'h0148);
      cmd(ssr_pkg::SSR_CMD_CLS, 16'h0000);
      chk({err_clear_o, 7'h00, srq_o, 7'h00}, 16'h8000);
      rd(ssr_pkg::SSR_CMD_READ_STB, 16'h0048);
      sum_i.error_available_bit = 1'b0;
      ops_idle_i = 1'b0;
      cmd(ssr_pkg::SSR_CMD_OPC, 16'h0000);
      tick(3);
      rd(ssr_pkg::SSR_CMD_READ_ESR, 16'h0000);
      ops_idle_i = 1'b1;
      tick(2);
      rd(ssr_pkg::SSR_CMD_READ_ESR, 16'h0001);
      ops_idle_i = 1'b0;
      cmd(ssr_pkg::SSR_CMD_OPC, 16'h0000);
      cmd(ssr_pkg::SSR_CMD_CLS, 16'h0000);
      ops_idle_i = 1'b1;
      tick(2);
      rd(ssr_pkg::SSR_CMD_READ_ESR, 16'h0000);
      // held event must survive until clear-status, reset command or device clear
      for (int k = 0; k < 3; k++) begin
         evt(4'h1);
         tick(3);
         chk({8'h00, stb_o}, 16'h0020);
         if (k == 0) cmd(ssr_pkg::SSR_CMD_CLS, 16'h0000);
         else if (k == 1) cmd(ssr_pkg::SSR_CMD_RST, 16'h0000);
         else begin
            dev_clear_i = 1'b1;
            tick(1);
            dev_clear_i = 1'b0;
         end
         rd(ssr_pkg::SSR_CMD_READ_ESR, 16'h0000);
      end
      cmd(ssr_pkg::ssr_cmd_e'(4'hf), 16'h0000);
      chk({15'h0000, resp_valid_o}, 16'h0000);
      rd(ssr_pkg::SSR_CMD_READ_ESE, 16'h00bd);
      rst_i = 1'b1;
      tick(2);
      rst_i = 1'b0;
      rd(ssr_pkg::SSR_CMD_READ_ESE, 16'h0000);
      rd(ssr_pkg::SSR_CMD_READ_SRE, 16'h0000);
      close_out();
   end
endmodule : ssr_status_tb
